// ---- logic/cbra_cfg.svh ----
// Timing and encoding constants for the bus and resource controller
`ifndef CBRA_CFG_SVH
`define CBRA_CFG_SVH
`define CBRA_CLK_NS 40
`define CBRA_DS_MIN_NS 100
`define CBRA_DS_MIN_CYC ((`CBRA_DS_MIN_NS + `CBRA_CLK_NS - 1) / `CBRA_CLK_NS)
`define CBRA_AD_W 16
`define CBRA_ST_W 4
`define CBRA_ST_MEM_BIT 3
`define CBRA_ST_IDLE 4'h0
`define CBRA_CNT_W 3
`define CBRA_DLY_W 16
`endif

// ---- logic/cbra_pkg.sv ----
// State types for the bus and resource controller
package cbra_pkg;
    typedef enum logic [3:0] {
        B_IDLE = 4'h0,
        B_ARB = 4'h1,
        B_ACQ = 4'h2,
        B_ADDR = 4'h3,
        B_LATCH = 4'h4,
        B_DATA = 4'h5,
        B_END = 4'h6,
        B_FLOAT = 4'h7,
        B_LEAVE = 4'h8
    } cbra_bus_type;
    typedef enum logic [1:0] {
        R_IDLE = 2'h0,
        R_CHECK = 2'h1,
        R_DELAY = 2'h2,
        R_TEST = 2'h3
    } cbra_res_type;
endpackage : cbra_pkg

// ---- logic/cbra_res_if.sv ----
// Link between the bus controller and the resource requester
`timescale 1ns/1ns
`include "cbra_cfg.svh"
interface cbra_res_if;
    logic start;
    logic release_;
    logic [`CBRA_DLY_W-1:0] delay;
    logic busySync;
    logic grantSync;
    logic done;
    logic granted;
    logic busyFlag;
    logic requestLine;
    logic grantOut;
    modport ctrl (output start, release_, delay, busySync, grantSync,
        input done, granted, busyFlag, requestLine, grantOut);
    modport res (input start, release_, delay, busySync, grantSync,
        output done, granted, busyFlag, requestLine, grantOut);
endinterface : cbra_res_if

// ---- logic/cbra_resource.sv ----
// Resource request sequencer: test, request, delay, test grant
`timescale 1ns/1ns
`include "cbra_cfg.svh"
module cbra_resource (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link to the controller
    cbra_res_if.res link
);
    cbra_pkg::cbra_res_type state;
    logic [`CBRA_DLY_W-1:0] count;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= cbra_pkg::R_IDLE;
            count <= '0;
            link.requestLine <= 1'b0;
            link.granted <= 1'b0;
            link.busyFlag <= 1'b0;
            link.done <= 1'b0;
        end else begin
            link.done <= 1'b0;
            case (state)
                cbra_pkg::R_IDLE: begin
                    if (link.release_) begin
                        link.requestLine <= 1'b0;
                        link.granted <= 1'b0;
                    end else if (link.start) begin
                        state <= cbra_pkg::R_CHECK;
                    end
                end
                cbra_pkg::R_CHECK: begin
                    link.busyFlag <= link.busySync;
                    if (link.busySync) begin
                        link.done <= 1'b1;
                        state <= cbra_pkg::R_IDLE;
                    end else begin
                        link.requestLine <= 1'b1;
                        count <= link.delay;
                        state <= cbra_pkg::R_DELAY;
                    end
                end
                cbra_pkg::R_DELAY: begin
                    count <= count - 1'b1;
                    if (count == '0) begin
                        state <= cbra_pkg::R_TEST;
                    end
                end
                cbra_pkg::R_TEST: begin
                    link.granted <= link.grantSync;
                    link.requestLine <= link.grantSync;
                    link.done <= 1'b1;
                    state <= cbra_pkg::R_IDLE;
                end
                default: state <= cbra_pkg::R_IDLE;
            endcase
        end
    end

    // Chain member: pass the grant only while not requesting
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            link.grantOut <= 1'b0;
        end else begin
            link.grantOut <= link.grantSync && !link.requestLine
                && state != cbra_pkg::R_CHECK;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_busy_abandon: assert property (
        state == cbra_pkg::R_CHECK && link.busySync |=> !link.requestLine && link.busyFlag)
        else $error("busy resource was requested");
    a_request_delay: assert property (
        state == cbra_pkg::R_CHECK && !link.busySync |=> link.requestLine ##1
        (state == cbra_pkg::R_DELAY && link.requestLine))
        else $error("request not raised for delay");
    a_grant_test: assert property (
        state == cbra_pkg::R_TEST |=> link.granted == $past(link.grantSync)
        && link.requestLine == $past(link.grantSync))
        else $error("grant test result wrong");
    a_chain_hold: assert property (
        link.requestLine |=> !link.grantOut)
        else $error("grant passed while requesting");
endmodule : cbra_resource

// ---- logic/cbra_host.sv ----
// Bus master and resource user facing the processor pins
`timescale 1ns/1ns
`include "cbra_cfg.svh"
// Operation
// - Sample resource busy first; if busy, abandon and flag busy.
// - If free, raise resource request and count down a 16-bit delay.
// - After delay, test chain grant; set success flag or drop request.
// - Arbitration grants only the highest-priority requestor via grant chain.
// - No default master; no user seizes a held or requested resource.
// - Sample shared bus request first; wait while it is active.
// - When idle, assert request, await grant-in, block grant-out, take bus.
// - Read data may be driven after data strobe falls; captured at rise.
// - Byte memory access: even address is high byte, odd is low.
// - I/O byte access: low address bit selects bus half.
// - Wait input low stretches the transaction until sampled high.
// - Hold bus request through transactions, float outputs, then release request.
module cbra_host (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Transaction commands
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdWrite,
    input wire logic cmdByte,
    input wire logic [`CBRA_ST_W-1:0] cmdType,
    input wire logic [`CBRA_AD_W-1:0] cmdAddr,
    input wire logic [`CBRA_AD_W-1:0] cmdWData,
    output logic rspValid,
    output logic [`CBRA_AD_W-1:0] rspRData,
    // Resource commands
    input wire logic resStart,
    input wire logic resRelease,
    input wire logic [`CBRA_DLY_W-1:0] resDelay,
    output logic resDone,
    output logic resGranted,
    output logic resBusy,
    // Bus request chain, open-drain request line
    input wire logic sharedBusRequestLineIn,
    output logic sharedBusRequestLineOut,
    output logic sharedBusRequestLineOe,
    input wire logic busGrantChainInN,
    output logic busGrantChainOutN,
    // Multiplexed bus and control while master
    input wire logic [`CBRA_AD_W-1:0] muxedAddrDataBusIn,
    output logic [`CBRA_AD_W-1:0] muxedAddrDataBusOut,
    output logic muxedAddrDataBusOe,
    output logic addressStrobeN,
    output logic dataStrobeN,
    output logic readWrite,
    output logic byteWord,
    output logic [`CBRA_ST_W-1:0] transactionTypeOut,
    output logic memoryCycleN,
    output logic controlOe,
    input wire logic waitN,
    // Resource chain
    input wire logic sharedResourceBusy,
    output logic resourceRequestLine,
    input wire logic resourceGrantIn,
    output logic resourceGrantOut
);
    function automatic logic isMemory(input logic [`CBRA_ST_W-1:0] code);
        isMemory = code[`CBRA_ST_MEM_BIT];
    endfunction : isMemory

    // Word memory accesses always go out on an even byte address
    function automatic logic [`CBRA_AD_W-1:0] alignAddr(input logic [`CBRA_AD_W-1:0] addr,
        input logic [`CBRA_ST_W-1:0] code, input logic isByte);
        alignAddr = {addr[`CBRA_AD_W-1:1], addr[0] && !(isMemory(code) && !isByte)};
    endfunction : alignAddr

    cbra_pkg::cbra_bus_type state;
    cbra_pkg::cbra_bus_type next_state;
    logic [4:0] syncA;
    logic [4:0] syncB;
    logic [`CBRA_AD_W-1:0] adSyncA;
    logic [`CBRA_AD_W-1:0] adSync;
    logic grantSyncN;
    logic brqIdle;
    logic waitSync;
    logic [`CBRA_CNT_W-1:0] dsCount;
    logic taken;
    logic dsDone;
    logic [`CBRA_AD_W-1:0] curAddr;
    logic [`CBRA_AD_W-1:0] curData;

    cbra_res_if resLink ();
    cbra_resource u_resource (
        .clock(clock),
        .rst_n(rst_n),
        .link(resLink.res)
    );

    assign grantSyncN = syncB[4];
    assign brqIdle = syncB[3];
    assign waitSync = syncB[2];
    assign resLink.busySync = syncB[1];
    assign resLink.grantSync = syncB[0];
    assign resLink.start = resStart;
    assign resLink.release_ = resRelease;
    assign resLink.delay = resDelay;
    assign resDone = resLink.done;
    assign resGranted = resLink.granted;
    assign resBusy = resLink.busyFlag;
    assign resourceRequestLine = resLink.requestLine;
    assign resourceGrantOut = resLink.grantOut;
    assign sharedBusRequestLineOut = 1'b0;
    assign taken = cmdValid && cmdReady;
    assign dsDone = waitSync && dsCount >= `CBRA_CNT_W'(`CBRA_DS_MIN_CYC - 1);

    // Pin synchronisers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 5'h1c;
            syncB <= 5'h1c;
            adSyncA <= '0;
            adSync <= '0;
        end else begin
            syncA <= {busGrantChainInN, sharedBusRequestLineIn, waitN,
                sharedResourceBusy, resourceGrantIn};
            syncB <= syncA;
            adSyncA <= muxedAddrDataBusIn;
            adSync <= adSyncA;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            cbra_pkg::B_IDLE: if (taken) next_state = cbra_pkg::B_ARB;
            cbra_pkg::B_ARB: if (brqIdle) next_state = cbra_pkg::B_ACQ;
            cbra_pkg::B_ACQ: if (!grantSyncN) next_state = cbra_pkg::B_ADDR;
            cbra_pkg::B_ADDR: next_state = cbra_pkg::B_LATCH;
            cbra_pkg::B_LATCH: next_state = cbra_pkg::B_DATA;
            cbra_pkg::B_DATA: if (dsDone) next_state = cbra_pkg::B_END;
            cbra_pkg::B_END: next_state = taken ? cbra_pkg::B_ADDR : cbra_pkg::B_FLOAT;
            cbra_pkg::B_FLOAT: next_state = cbra_pkg::B_LEAVE;
            cbra_pkg::B_LEAVE: next_state = cbra_pkg::B_IDLE;
            default: next_state = cbra_pkg::B_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= cbra_pkg::B_IDLE;
            cmdReady <= 1'b0;
        end else begin
            state <= next_state;
            cmdReady <= next_state == cbra_pkg::B_IDLE || next_state == cbra_pkg::B_END;
        end
    end

    // Command capture; word memory addresses forced even
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            curAddr <= '0;
            curData <= '0;
            readWrite <= 1'b1;
            byteWord <= 1'b0;
            transactionTypeOut <= `CBRA_ST_IDLE;
            memoryCycleN <= 1'b1;
        end else if (taken) begin
            curAddr <= alignAddr(cmdAddr, cmdType, cmdByte);
            curData <= cmdByte ? {cmdWData[7:0], cmdWData[7:0]} : cmdWData;
            readWrite <= !cmdWrite;
            byteWord <= cmdByte;
            transactionTypeOut <= cmdType;
            memoryCycleN <= !isMemory(cmdType);
        end
    end

    // Bus request line and grant chain
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sharedBusRequestLineOe <= 1'b0;
            busGrantChainOutN <= 1'b1;
        end else begin
            sharedBusRequestLineOe <= (state == cbra_pkg::B_ARB && brqIdle)
                || (sharedBusRequestLineOe && state != cbra_pkg::B_LEAVE);
            busGrantChainOutN <= sharedBusRequestLineOe || grantSyncN;
        end
    end

    // Strobes and bus drive
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addressStrobeN <= 1'b1;
            dataStrobeN <= 1'b1;
            controlOe <= 1'b0;
            muxedAddrDataBusOe <= 1'b0;
            muxedAddrDataBusOut <= '0;
            dsCount <= '0;
        end else begin
            addressStrobeN <= next_state != cbra_pkg::B_ADDR;
            dataStrobeN <= next_state != cbra_pkg::B_DATA;
            controlOe <= next_state inside {cbra_pkg::B_ADDR, cbra_pkg::B_LATCH,
                cbra_pkg::B_DATA, cbra_pkg::B_END};
            dsCount <= (state == cbra_pkg::B_DATA) ? dsCount + 1'b1 : '0;
            if (next_state == cbra_pkg::B_ADDR) begin
                muxedAddrDataBusOe <= 1'b1;
                muxedAddrDataBusOut <= taken ? alignAddr(cmdAddr, cmdType, cmdByte) : curAddr;
            end else if (next_state == cbra_pkg::B_LATCH) begin
                muxedAddrDataBusOe <= !readWrite;
                muxedAddrDataBusOut <= curData;
            end else if (next_state != cbra_pkg::B_DATA && next_state != cbra_pkg::B_END) begin
                muxedAddrDataBusOe <= 1'b0;
            end
        end
    end

    // Read capture as the data strobe rises; byte lane by low address bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rspValid <= 1'b0;
            rspRData <= '0;
        end else begin
            rspValid <= state == cbra_pkg::B_DATA && dsDone;
            if (state == cbra_pkg::B_DATA && dsDone && readWrite) begin
                rspRData <= !byteWord ? adSync :
                    {8'h00, curAddr[0] ? adSync[7:0] : adSync[15:8]};
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence addrPhase;
        !addressStrobeN && dataStrobeN ##1 addressStrobeN && dataStrobeN;
    endsequence
    sequence dataPhase;
        !dataStrobeN [*3];
    endsequence

    a_brq_sample_first: assert property (
        $rose(sharedBusRequestLineOe) |-> $past(brqIdle))
        else $error("bus request driven while line active");
    a_chain_blocked: assert property (
        sharedBusRequestLineOe |=> busGrantChainOutN)
        else $error("grant passed while requesting bus");
    a_float_then_drop: assert property (
        $fell(sharedBusRequestLineOe) |-> !controlOe && !$past(controlOe))
        else $error("request released before outputs floated");
    a_strobe_order: assert property (
        $fell(addressStrobeN) |-> addrPhase ##1 dataPhase)
        else $error("strobe order broken");
    a_wait_stretch: assert property (
        state == cbra_pkg::B_DATA && !waitSync |=> !dataStrobeN)
        else $error("wait ignored");
    a_word_even: assert property (
        !addressStrobeN && !byteWord && !memoryCycleN |-> !muxedAddrDataBusOut[0])
        else $error("odd word memory address");
    a_write_hold: assert property (
        $rose(dataStrobeN) && !readWrite |-> muxedAddrDataBusOe && $stable(muxedAddrDataBusOut))
        else $error("write data removed at strobe rise");
    a_qual_stable: assert property (
        !dataStrobeN |-> $stable(readWrite) && $stable(byteWord) && $stable(transactionTypeOut))
        else $error("qualifiers changed mid transaction");
endmodule : cbra_host

// ---- dv/cbra_partner.sv ----
// Far-side model: processor grant source, memory or port, wait insertion
`timescale 1ns/1ns
module cbra_partner (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Request chain and wire level of the bus
    input wire logic sharedBusRequestLineIn,
    output logic busGrantChainInN,
    input wire logic [15:0] muxedAddrDataBusIn,
    output logic [15:0] busOut,
    // Strobes and qualifiers
    input wire logic addressStrobeN,
    input wire logic dataStrobeN,
    input wire logic readWrite,
    input wire logic byteWord,
    input wire logic [3:0] transactionTypeOut,
    input wire logic memoryCycleN,
    // Wait control and observation
    input wire logic [7:0] nWait,
    output logic waitN,
    output logic [15:0] pAddr,
    output logic [15:0] pWr,
    output logic [7:0] pDsLen,
    output logic [7:0] pErr,
    output logic [6:0] pQual
);
    logic [15:0] mem [0:15];
    logic [15:0] busIdle;
    logic bad;
    // Idle processor: acknowledge follows the request line one cycle later
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) busGrantChainInN <= 1'b1;
        else busGrantChainInN <= sharedBusRequestLineIn;
    end
    // Last value seen before the address strobe rises is the latched one
    always_ff @(posedge clock) begin
        if (!addressStrobeN) begin
            pAddr <= muxedAddrDataBusIn;
            pQual <= {readWrite, byteWord, memoryCycleN, transactionTypeOut};
        end
    end
    assign waitN = pDsLen >= nWait;
    // Selected device drives read data as soon as the data strobe falls
    assign busOut = (!dataStrobeN && pQual[6]) ? mem[pAddr[4:1]] : busIdle;
    // Qualifiers or write data moving while the data strobe is low
    assign bad = !dataStrobeN && ({readWrite, byteWord} !== pQual[6:5]
        || (!pQual[6] && pDsLen != 8'h00 && muxedAddrDataBusIn !== pWr));
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pDsLen <= 8'h00;
            pErr <= 8'h00;
            busIdle <= 16'h0000;
        end else begin
            pErr <= pErr + {7'h00, bad};
            if (!addressStrobeN) pDsLen <= 8'h00;
            else if (!dataStrobeN) pDsLen <= pDsLen + 8'h01;
            // Released bus shows a changing pattern, never the last value
            busIdle <= ~busIdle;
        end
    end
    always_ff @(posedge clock) begin
        if (!dataStrobeN && !pQual[6]) begin
            pWr <= muxedAddrDataBusIn;
            if (!pQual[5] || !pAddr[0]) mem[pAddr[4:1]][15:8] <= muxedAddrDataBusIn[15:8];
            if (!pQual[5] || pAddr[0]) mem[pAddr[4:1]][7:0] <= muxedAddrDataBusIn[7:0];
        end
    end
endmodule : cbra_partner

// ---- dv/cbra_host_tb.sv ----
// Self-checking bench for the bus master and resource user
`timescale 1ns/1ns
module cbra_host_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cmdValid = 1'b0, cmdWrite = 1'b0, cmdByte = 1'b0, otherMaster = 1'b0;
    logic resStart = 1'b0, resRelease = 1'b0, sharedResourceBusy = 1'b0, resourceGrantIn = 1'b0;
    logic [3:0] cmdType = 4'h8;
    logic [15:0] cmdAddr = 16'h0000, cmdWData = 16'h0000, resDelay = 16'h0005;
    logic [7:0] nWait = 8'h00;
    logic cmdReady, rspValid, resDone, resGranted, resBusy, sharedBusRequestLineIn;
    logic sharedBusRequestLineOut, sharedBusRequestLineOe, busGrantChainInN, busGrantChainOutN;
    logic muxedAddrDataBusOe, addressStrobeN, dataStrobeN, readWrite, byteWord, memoryCycleN;
    logic controlOe, waitN, resourceRequestLine, resourceGrantOut;
    logic [3:0] transactionTypeOut;
    logic [15:0] rspRData, muxedAddrDataBusIn, muxedAddrDataBusOut, busOut, pAddr, pWr;
    logic [7:0] pDsLen, pErr;
    logic [6:0] pQual;
    int n_fail = 0, tests_run = 0, cyc = 0;
    // Open-drain request line with pull-up; another master may pull it
    assign sharedBusRequestLineIn = (sharedBusRequestLineOe ? sharedBusRequestLineOut : 1'b1)
        & ~otherMaster;
    assign muxedAddrDataBusIn = muxedAddrDataBusOe ? muxedAddrDataBusOut : busOut;
    cbra_host u_cbra_host (.*);
    cbra_partner u_cbra_partner (.*);
    always #20 clock = ~clock;
    task automatic complete_run;
        if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    always @(negedge clock) begin
        cyc++;
        if (controlOe === 1'b1) check("master pins", {10'h0, 1'b1, ~cmdType[3], cmdType},
            {10'h0, busGrantChainOutN, memoryCycleN, transactionTypeOut});
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic issue(input logic w, b, input logic [3:0] t, input logic [15:0] a, d);
        int n = 0;
        {cmdWrite, cmdByte, cmdType, cmdAddr, cmdWData} = {w, b, t, a, d};
        cmdValid = 1'b1;
        while (cmdReady !== 1'b1 && n < 50) begin
            @(posedge clock);
            #1 n++;
        end
        @(posedge clock);
        #1 cmdValid = 1'b0;
    endtask : issue
    task automatic finish;
        int n = 0;
        while (rspValid !== 1'b1 && n < 400) begin
            @(posedge clock);
            #1 n++;
        end
        check("response", 16'h0001, {15'h0, rspValid});
        repeat (2) @(posedge clock);
        #1;
    endtask : finish
    task automatic xfer(input logic w, b, input logic [3:0] t, input logic [15:0] a, d);
        issue(w, b, t, a, d);
        finish();
    endtask : xfer
    task automatic t_memory;
        xfer(1'b1, 1'b0, 4'h8, 16'h0013, 16'hbeef);
        check("word address", 16'h0012, pAddr);
        check("write data", 16'hbeef, pWr);
        check("write quals", 16'h0008, {9'h0, pQual});
        xfer(1'b0, 1'b0, 4'hd, 16'h0012, 16'h0000);
        check("read data", 16'hbeef, rspRData);
        check("read quals", 16'h004d, {9'h0, pQual});
        xfer(1'b1, 1'b1, 4'h9, 16'h0012, 16'h005a);
        check("byte copy", 16'h5a5a, pWr);
        xfer(1'b1, 1'b1, 4'h9, 16'h0013, 16'h00c3);
        check("byte quals", 16'h0029, {9'h0, pQual});
        xfer(1'b0, 1'b0, 4'h8, 16'h0012, 16'h0000);
        check("byte lanes", 16'h5ac3, rspRData);
        xfer(1'b0, 1'b1, 4'h8, 16'h0013, 16'h0000);
        check("odd byte", 16'h00c3, {8'h00, rspRData[7:0]});
        xfer(1'b0, 1'b1, 4'h8, 16'h0012, 16'h0000);
        check("even byte", 16'h005a, {8'h00, rspRData[7:0]});
        check("strobe hold", 16'h0000, {8'h00, pErr});
    endtask : t_memory
    task automatic t_codes;
        logic [3:0] codes [6] = '{4'h2, 4'h3, 4'h8, 4'h9, 4'hc, 4'hd};
        foreach (codes[i]) begin
            xfer(1'b0, 1'b0, codes[i], 16'h0012, 16'h0000);
            check("type code", {9'h0, 2'b10, ~codes[i][3], codes[i]}, {9'h0, pQual});
        end
        xfer(1'b1, 1'b1, 4'h2, 16'h0041, 16'h0077);
        check("port byte", 16'h7777, pWr);
        check("port address", 16'h0041, pAddr);
        nWait = 8'h06;
        xfer(1'b0, 1'b0, 4'h8, 16'h0012, 16'h0000);
        nWait = 8'h00;
        check("wait stretch", 16'h0001, {15'h0, pDsLen >= 8'h06});
        check("wait data", 16'h5ac3, rspRData);
    endtask : t_codes
    // Second command taken in the end cycle keeps the bus
    task automatic t_burst;
        issue(1'b1, 1'b0, 4'h8, 16'h0015, 16'h1234);
        @(posedge clock);
        #1 issue(1'b0, 1'b0, 4'h8, 16'h0015, 16'h0000);
        finish();
        check("burst address", 16'h0014, pAddr);
        check("burst read", 16'h1234, rspRData);
    endtask : t_burst
    task automatic t_defer;
        otherMaster = 1'b1;
        issue(1'b0, 1'b0, 4'h8, 16'h0012, 16'h0000);
        repeat (10) begin
            @(posedge clock);
            #1 check("defer", 16'h0000, {14'h0, sharedBusRequestLineOe, controlOe});
        end
        otherMaster = 1'b0;
        finish();
        check("deferred read", 16'h5ac3, rspRData);
    endtask : t_defer
    task automatic res_try(input logic busy, gnt, output int k, output logic seen);
        sharedResourceBusy = busy;
        resourceGrantIn = gnt;
        repeat (3) @(posedge clock);
        #1 resStart = 1'b1;
        k = 0;
        seen = 1'b0;
        @(posedge clock);
        #1 resStart = 1'b0;
        while (resDone !== 1'b1 && k < 100) begin
            @(posedge clock);
            #1 k++;
            seen = seen | resourceRequestLine;
        end
    endtask : res_try
    task automatic res_drop;
        @(posedge clock);
        #1 resRelease = 1'b1;
        @(posedge clock);
        #1 resRelease = 1'b0;
        #80 check("release", 16'h0000, {14'h0, resourceRequestLine, resGranted});
    endtask : res_drop
    task automatic t_resource;
        int k1, k2;
        logic seen;
        resourceGrantIn = 1'b1;
        repeat (3) @(posedge clock);
        #1 check("chain pass", 16'h0001, {15'h0, resourceGrantOut});
        res_try(1'b1, 1'b1, k1, seen);
        check("busy flag", 16'h0002, {14'h0, resBusy, resGranted});
        check("no request", 16'h0000, {15'h0, seen});
        check("busy quick", 16'h0001, {15'h0, k1 <= 3});
        res_try(1'b0, 1'b1, k1, seen);
        check("granted", 16'h0001, {14'h0, resBusy, resGranted});
        check("requested", 16'h0001, {15'h0, seen});
        res_drop();
        resDelay = 16'h0014;
        res_try(1'b0, 1'b1, k2, seen);
        check("delay count", 16'h000f, k2[15:0] - k1[15:0]);
        res_drop();
        res_try(1'b0, 1'b0, k1, seen);
        #80 check("denied", 16'h0000, {13'h0, resBusy, resGranted, resourceRequestLine});
    endtask : t_resource
    initial begin
        repeat (3) @(posedge clock);
        #1 check("reset pins", 16'h0038, {10'h0, addressStrobeN, dataStrobeN, busGrantChainOutN,
            sharedBusRequestLineOe, controlOe, cmdReady});
        repeat (2) @(posedge clock);
        #1 rst_n = 1'b1;
        t_memory();
        t_codes();
        t_burst();
        t_defer();
        t_resource();
        complete_run();
    end
endmodule : cbra_host_tb
